// [rtl/adc_host_port.sv]
// Parallel host port of a four-input sampling converter
//
// Function
// - Continuous mode: external clock on the pace pin paces every conversion.
// - Single mode: falling pace pin edge holds inputs and starts one conversion.
// - Two chip selects: first active low, second active high.
// - Sample-ready flag polarity is programmable, low or high active.
// - Sample-ready flag acts as static level or one-cycle pulse.
// - Sample-ready flag follows FIFO fill level, usable as interrupt request.
// - Twelve-bit tri-state data bus, bit 0 least, bit 11 most significant.
// - On register writes bits 10 and 11 select the control register.
// - Write strobe is programmable: read/write direction line or active-low write.
// - Read select counts only when write strobe is configured write-only.
// - Control register 0 chooses internal or external reference.
// - Internal oscillator runs in single mode, stops in continuous mode.
// - Converted samples wait in a sixteen-word FIFO.
module adc_host_port
   import adc_port_pkg::*;
(
   // Clock and reset
   input  wire logic                              core_clk,
   input  wire logic                              rst_b,
   // Chip selects
   input  wire logic                              select_low_n,
   input  wire logic                              select_high,
   // Strobes
   input  wire logic                              write_strobe,
   input  wire logic                              read_select_n,
   // Data bus, split into its three signals
   input  wire logic [adc_port_pkg::DATA_W-1:0]   bus_data_in,
   output logic      [adc_port_pkg::DATA_W-1:0]   bus_data_out,
   output logic                                   bus_data_oe,
   // Conversion pin
   input  wire logic                              conversion_pace_in,
   // Converter core side
   input  wire logic [adc_port_pkg::DATA_W-1:0]   sample_data,
   input  wire logic                              sample_valid,
   output logic                                   conv_launch,
   output logic                                   osc_enable,
   output logic                                   ref_external,
   // Flag and interrupt
   output logic                                   sample_ready_flag,
   output logic                                   irq
);
   import adc_port_pkg::*;

   top_state_type q;
   top_state_type n;
   fifo_link_if   fifo ();

   // Sample storage
   sample_fifo u_fifo (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .link     (fifo.store)
   );

   // Decoded configuration
   logic                wr_only;
   logic                single_mode;
   logic                pol_high;
   logic                pulse_mode;
   logic [CNT_W-1:0]    level_thr;

   assign wr_only     = q.cr1[CR1_WR_ONLY_BIT];
   assign single_mode = q.cr0[CR0_SINGLE_BIT];
   assign pol_high    = q.cr1[CR1_POL_HIGH_BIT];
   assign pulse_mode  = q.cr1[CR1_PULSE_BIT];
   assign level_thr   = q.cr1[CR1_LEVEL_MSB:CR1_LEVEL_LSB];

   // Fill level non-zero and at or above the programmed threshold
   function automatic logic level_reached(input logic [CNT_W-1:0] cnt,
                                          input logic [CNT_W-1:0] thr);
      level_reached = (cnt != '0) && (cnt >= thr);
   endfunction : level_reached

   // Bus request decoding from synchronised pins
   logic sel;
   logic wr_req;
   logic rd_req;

   assign sel    = q.sel_s2;
   assign wr_req = sel && !q.wr_s2;
   assign rd_req = sel && q.wr_s2 && (!wr_only || !q.rd_s2);

   // Events and commits of this cycle
   logic                level_now;
   logic                pace_fall;
   logic                pace_rise;
   logic                read_end;
   logic                write_end;
   logic [1:0]          waddr;
   logic [STAT_W-1:0]   ev;

   assign level_now = level_reached(fifo.count, level_thr);
   assign pace_fall = q.pace_prev && !q.pace_s2;
   assign pace_rise = !q.pace_prev && q.pace_s2;
   assign read_end  = (q.bus_st == ST_READ) && !rd_req;
   assign write_end = (q.bus_st == ST_WRITE) && !wr_req;
   assign waddr     = q.wdata[ADDR_MSB:ADDR_LSB];

   // FIFO feed and drain
   assign fifo.push      = sample_valid;
   assign fifo.push_data = sample_data;
   assign fifo.pop       = read_end && !q.stat_pending;

   // Status events: level reached, overflow, conversion launched
   always_comb begin
      ev                  = '0;
      ev[EV_LEVEL_BIT]    = level_now && !q.level_prev;
      ev[EV_OVERFLOW_BIT] = sample_valid && fifo.full;
      ev[EV_CONV_BIT]     = q.conv;
   end

   // Next state of the whole port
   always_comb begin
      logic flag_active;
      flag_active = 1'b0;
      n = q;

      // Two-stage synchronisers on every pin
      n.sel_s1  = !select_low_n && select_high;
      n.sel_s2  = q.sel_s1;
      n.wr_s1   = write_strobe;
      n.wr_s2   = q.wr_s1;
      n.rd_s1   = read_select_n;
      n.rd_s2   = q.rd_s1;
      n.pace_s1 = conversion_pace_in;
      n.pace_s2 = q.pace_s1;
      n.data_s1 = bus_data_in;
      n.data_s2 = q.data_s1;
      n.pace_prev = q.pace_s2;

      // Host bus sequencer
      unique case (q.bus_st)
         ST_IDLE: begin
            if (wr_req) begin
               n.bus_st = ST_WRITE;
               n.wdata  = q.data_s2;
            end else if (rd_req) begin
               n.bus_st = ST_READ;
               n.doe    = 1'b1;
               if (q.stat_pending) begin
                  n.dout = DATA_W'(q.stat);
               end else begin
                  n.dout = fifo.head;
               end
            end
         end
         ST_WRITE: begin
            if (wr_req) begin
               n.wdata = q.data_s2;
            end else begin
               n.bus_st = ST_IDLE;
               unique case (waddr)
                  ADDR_CR0:  n.cr0 = q.wdata[CFG_W-1:0];
                  ADDR_CR1:  n.cr1 = q.wdata[CFG_W-1:0];
                  ADDR_MASK: n.mask = q.wdata[STAT_W-1:0];
                  ADDR_STAT: n.stat_pending = 1'b1;
               endcase
            end
         end
         ST_READ: begin
            if (!rd_req) begin
               n.bus_st = ST_IDLE;
               n.doe    = 1'b0;
               n.stat_pending = 1'b0;
            end
         end
      endcase

      // Conversion launch from the pace pin
      if (single_mode) begin
         n.conv = pace_fall;
      end else begin
         n.conv = pace_rise;
      end

      // Sticky status; a new event wins over the read clear
      if (read_end && q.stat_pending) begin
         n.stat = ev;
      end else begin
         n.stat = q.stat | ev;
      end

      // Sample-ready flag: level or pulse, then polarity
      n.level_prev = level_now;
      if (pulse_mode) begin
         flag_active = level_now && !q.level_prev;
      end else begin
         flag_active = level_now;
      end
      n.flag = flag_active ~^ pol_high;

      n.irq = |(n.stat & q.mask);
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= TOP_RESET;
      end else begin
         q <= n;
      end
   end

   // Outputs straight from the state register
   assign bus_data_out      = q.dout;
   assign bus_data_oe       = q.doe;
   assign conv_launch       = q.conv;
   assign osc_enable        = q.cr0[CR0_SINGLE_BIT];
   assign ref_external      = q.cr0[CR0_REF_EXT_BIT];
   assign sample_ready_flag = q.flag;
   assign irq               = q.irq;

endmodule : adc_host_port

// [rtl/adc_port_pkg.sv]
// Shared constants, types and reset values of the parallel host port
package adc_port_pkg;

   // Widths and depths
   localparam int DATA_W     = 12;
   localparam int CFG_W      = 10;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W      = 4;
   localparam int CNT_W      = 5;
   localparam int STAT_W     = 3;

   // Control register address field carried on the top two bus bits
   localparam int ADDR_MSB = 11;
   localparam int ADDR_LSB = 10;
   localparam logic [1:0] ADDR_CR0  = 2'h0;
   localparam logic [1:0] ADDR_CR1  = 2'h1;
   localparam logic [1:0] ADDR_MASK = 2'h2;
   localparam logic [1:0] ADDR_STAT = 2'h3;

   // Control register 0 fields
   localparam int CR0_REF_EXT_BIT = 0;
   localparam int CR0_SINGLE_BIT  = 1;

   // Control register 1 fields
   localparam int CR1_WR_ONLY_BIT  = 0;
   localparam int CR1_POL_HIGH_BIT = 1;
   localparam int CR1_PULSE_BIT    = 2;
   localparam int CR1_LEVEL_LSB    = 3;
   localparam int CR1_LEVEL_MSB    = 7;

   // Status and mask bit positions
   localparam int EV_LEVEL_BIT    = 0;
   localparam int EV_OVERFLOW_BIT = 1;
   localparam int EV_CONV_BIT     = 2;

   // Reset values
   localparam logic [CFG_W-1:0]  CR0_RESET  = 10'h000;
   localparam logic [CFG_W-1:0]  CR1_RESET  = 10'h008;
   localparam logic [STAT_W-1:0] MASK_RESET = 3'h0;
   localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;
   localparam logic              FLAG_PIN_RESET = 1'b1;

   // Host bus sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ  = 3'b100
   } bus_state_type;

   // Complete state of the top module
   typedef struct packed {
      logic                   sel_s1;
      logic                   sel_s2;
      logic                   wr_s1;
      logic                   wr_s2;
      logic                   rd_s1;
      logic                   rd_s2;
      logic                   pace_s1;
      logic                   pace_s2;
      logic                   pace_prev;
      logic [DATA_W-1:0]      data_s1;
      logic [DATA_W-1:0]      data_s2;
      logic [DATA_W-1:0]      wdata;
      bus_state_type          bus_st;
      logic [CFG_W-1:0]       cr0;
      logic [CFG_W-1:0]       cr1;
      logic [STAT_W-1:0]      mask;
      logic [STAT_W-1:0]      stat;
      logic                   stat_pending;
      logic                   level_prev;
      logic [DATA_W-1:0]      dout;
      logic                   doe;
      logic                   conv;
      logic                   flag;
      logic                   irq;
   } top_state_type;

   localparam top_state_type TOP_RESET = '{
      bus_st:  ST_IDLE,
      cr0:     CR0_RESET,
      cr1:     CR1_RESET,
      mask:    MASK_RESET,
      stat:    STAT_RESET,
      flag:    FLAG_PIN_RESET,
      default: '0
   };

   // Complete state of the sample FIFO
   typedef struct packed {
      logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
      logic [PTR_W-1:0]                  wr_ptr;
      logic [PTR_W-1:0]                  rd_ptr;
      logic [CNT_W-1:0]                  count;
   } fifo_state_type;

   localparam fifo_state_type FIFO_RESET = '0;

endpackage : adc_port_pkg

// [rtl/fifo_link_if.sv]
// Link between the host port logic and its sample FIFO
interface fifo_link_if;
   import adc_port_pkg::*;

   logic                push;
   logic [DATA_W-1:0]   push_data;
   logic                pop;
   logic [DATA_W-1:0]   head;
   logic [CNT_W-1:0]    count;
   logic                full;
   logic                empty;

   modport store (input push, input push_data, input pop,
                  output head, output count, output full, output empty);
   modport user  (output push, output push_data, output pop,
                  input head, input count, input full, input empty);
endinterface : fifo_link_if

// [rtl/sample_fifo.sv]
// Sixteen-word sample FIFO held in flip-flops
module sample_fifo
   import adc_port_pkg::*;
(
   // Clock and reset
   input  wire logic  core_clk,
   input  wire logic  rst_b,
   // Link to the port logic
   fifo_link_if.store link
);

   fifo_state_type q;
   fifo_state_type n;

   // Next state: write at the tail, read at the head
   always_comb begin
      logic do_push;
      logic do_pop;
      do_push = 1'b0;
      do_pop  = 1'b0;
      n = q;
      do_push = link.push && (q.count != CNT_W'(FIFO_DEPTH));
      do_pop  = link.pop && (q.count != '0);
      if (do_push) begin
         n.mem[q.wr_ptr] = link.push_data;
         n.wr_ptr        = q.wr_ptr + 4'h1;
      end
      if (do_pop) begin
         n.rd_ptr = q.rd_ptr + 4'h1;
      end
      if (do_push && !do_pop) begin
         n.count = q.count + 5'h01;
      end else if (do_pop && !do_push) begin
         n.count = q.count - 5'h01;
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= FIFO_RESET;
      end else begin
         q <= n;
      end
   end

   // Head word and fill state
   assign link.head  = q.mem[q.rd_ptr];
   assign link.count = q.count;
   assign link.full  = (q.count == CNT_W'(FIFO_DEPTH));
   assign link.empty = (q.count == '0);

endmodule : sample_fifo

// [tb/adc_host_port_assertions.sv]
// Concurrent checks on the pins of the host port
module adc_port_checker (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Pins seen by the checker
   input wire logic select_low_n,
   input wire logic select_high,
   input wire logic write_strobe,
   input wire logic conversion_pace_in,
   input wire logic sample_valid,
   input wire logic bus_data_oe,
   input wire logic conv_launch,
   input wire logic osc_enable,
   input wire logic ref_external,
   input wire logic sample_ready_flag,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;

   // All checks sample on the core clock and rest during reset
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   a_read_needs_sel: assert property ($rose(bus_data_oe) |-> !$past(select_low_n, 3) &&
      $past(select_high, 3) && $past(write_strobe, 3))
      else $error("bus driven without a selected read");
   a_oe_after_deselect: assert property (select_low_n [*4] |-> !bus_data_oe)
      else $error("bus still driven after deselect");
   a_no_drive_write: assert property (!write_strobe [*4] |-> !bus_data_oe)
      else $error("bus driven during a write");
   a_launch_one_cycle: assert property (conv_launch |=> !conv_launch)
      else $error("launch pulse longer than one cycle");
   a_launch_from_edge: assert property ($rose(conv_launch) |->
      $past(conversion_pace_in, 3) != osc_enable && $past(conversion_pace_in, 4) == osc_enable)
      else $error("launch without the matching pace edge");
   a_irq_holds: assert property (select_low_n [*6] ##0 irq |=> irq)
      else $error("interrupt dropped without an access");
   a_flag_quiet: assert property ((select_low_n && !sample_valid) [*6]
      |=> $stable(sample_ready_flag))
      else $error("flag moved without push or pop");
   a_cfg_quiet: assert property (select_low_n [*6] |=> $stable({osc_enable, ref_external}))
      else $error("configuration moved without a write");

   // Main scenarios reached
   c_read: cover property ($rose(bus_data_oe));
   c_irq: cover property ($rose(irq));
   c_launch: cover property ($rose(conv_launch));
endmodule : adc_port_checker

bind adc_host_port adc_port_checker u_checker (
   .core_clk(core_clk), .rst_b(rst_b), .select_low_n(select_low_n), .select_high(select_high),
   .write_strobe(write_strobe), .conversion_pace_in(conversion_pace_in),
   .sample_valid(sample_valid), .bus_data_oe(bus_data_oe), .conv_launch(conv_launch),
   .osc_enable(osc_enable), .ref_external(ref_external),
   .sample_ready_flag(sample_ready_flag), .irq(irq)
);

// [tb/adc_parallel_host_port_tb_top.sv]
// Self-checking bench of the parallel host port
module adc_parallel_host_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_port_pkg::*;

   logic              core_clk, rst_b, conversion_pace_in, sample_valid, oe;
   logic              select_low_n, select_high, write_strobe, read_select_n, host_oe;
   logic              bus_data_oe, conv_launch, osc_enable, ref_external, sample_ready_flag, irq;
   logic [DATA_W-1:0] host_d, bus_wire, bus_data_out, sample_data, d;
   logic [DATA_W-1:0] idle_pat = 12'h5A5;
   logic [11:0]       cr0_rows [4] = '{12'h000, 12'h006, 12'h009, 12'h00F};
   int                mismatches, samples_checked, n, flag_hi;

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Bus level: the driver wins, a released bus changes every cycle
   assign bus_wire = host_oe ? host_d : (bus_data_oe ? bus_data_out : idle_pat);
   always @(posedge core_clk) begin
      idle_pat <= idle_pat + 12'h001;
      if (sample_ready_flag === 1'b1) flag_hi++;
   end

   adc_host_port DUT (
      .core_clk(core_clk), .rst_b(rst_b), .select_low_n(select_low_n),
      .select_high(select_high), .write_strobe(write_strobe), .read_select_n(read_select_n),
      .bus_data_in(bus_wire), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
      .conversion_pace_in(conversion_pace_in), .sample_data(sample_data),
      .sample_valid(sample_valid), .conv_launch(conv_launch), .osc_enable(osc_enable),
      .ref_external(ref_external), .sample_ready_flag(sample_ready_flag), .irq(irq)
   );

   host_model host (
      .core_clk(core_clk), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
      .select_low_n(select_low_n), .select_high(select_high), .write_strobe(write_strobe),
      .read_select_n(read_select_n), .host_d(host_d), .host_oe(host_oe)
   );

   // Compare and count
   task automatic chk(input logic [DATA_W-1:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Read and compare the answer
   task automatic rd_chk(input logic wo, cs, input logic [DATA_W-1:0] exp, input logic exp_oe);
      logic [DATA_W-1:0] got;
      logic              seen;
      host.rd(wo, cs, got, seen);
      chk(seen, exp_oe);
      if (exp_oe) chk(got, exp);
   endtask : rd_chk

   // Converter core hands over cnt back-to-back samples
   task automatic push(input int cnt, input logic [DATA_W-1:0] base);
      for (int i = 0; i < cnt; i++) begin
         @(posedge core_clk);
         sample_valid <= 1'b1;
         sample_data  <= base + DATA_W'(i);
      end
      @(posedge core_clk);
      sample_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask : push

   // Move the pace pin and count launch pulses
   task automatic pace_edge(input logic v, input int exp);
      int cnt;
      cnt = 0;
      @(posedge core_clk);
      conversion_pace_in <= v;
      repeat (8) begin
         @(posedge core_clk);
         if (conv_launch === 1'b1) cnt++;
      end
      chk(DATA_W'(cnt), DATA_W'(exp));
   endtask : pace_edge

   // Verdict and end of run
   task automatic complete_run();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // Watchdog
   initial begin
      #50us;
      mismatches++;
      complete_run();
   end

   // Main sequence
   initial begin
      rst_b = 1'b0;
      conversion_pace_in = 1'b0;
      sample_valid = 1'b0;
      sample_data = '0;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      chk({bus_data_oe, sample_ready_flag, irq}, 12'h002);
      host.wr(ADDR_CR1, 10'h008);
      foreach (cr0_rows[i]) begin
         host.wr(ADDR_CR0, cr0_rows[i][11:2]);
         chk({ref_external, osc_enable}, cr0_rows[i][1:0]);
      end
      pace_edge(1'b1, 0);
      pace_edge(1'b0, 1);
      host.wr(ADDR_CR0, 10'h000);
      pace_edge(1'b1, 1);
      pace_edge(1'b0, 0);
      // Level flag, order and bus bits
      push(3, 12'h7FE);
      chk(sample_ready_flag, 12'h000);
      for (int i = 0; i < 3; i++) rd_chk(0, 1, 12'(12'h7FE + i), 1);
      chk(sample_ready_flag, 12'h001);
      // Half selected, then strobe modes
      push(1, 12'h123);
      rd_chk(0, 0, 12'h000, 0);
      host.wr(ADDR_CR1, 10'h009);
      rd_chk(0, 1, 12'h000, 0);
      rd_chk(1, 1, 12'h123, 1);
      // High-active pulse flag
      host.wr(ADDR_CR1, 10'h00E);
      chk(sample_ready_flag, 12'h000);
      n = flag_hi;
      push(1, 12'h456);
      repeat (4) @(posedge core_clk);
      chk(12'(flag_hi - n), 12'h001);
      rd_chk(0, 1, 12'h456, 1);
      // Overflow interrupt, masking and status clear
      host.wr(ADDR_STAT, 10'h000);
      host.rd(1'b0, 1'b1, d, oe);
      host.wr(ADDR_MASK, 10'h002);
      push(16, 12'h100);
      chk(irq, 12'h000);
      push(1, 12'h200);
      chk(irq, 12'h001);
      host.wr(ADDR_STAT, 10'h000);
      rd_chk(0, 1, 12'h003, 1);
      chk(irq, 12'h000);
      for (int i = 0; i < 16; i++) rd_chk(0, 1, 12'(12'h100 + i), 1);
      // Threshold of two words, high-active level flag
      host.wr(ADDR_CR1, 10'h012);
      push(1, 12'h321);
      chk(sample_ready_flag, 12'h000);
      push(1, 12'h322);
      chk(sample_ready_flag, 12'h001);
      rd_chk(0, 1, 12'h321, 1);
      chk(sample_ready_flag, 12'h000);
      rd_chk(0, 1, 12'h322, 1);
      complete_run();
   end
endmodule : adc_parallel_host_port_tb_top

// [tb/host_model.sv]
// Host processor model driving the parallel bus pins
module host_model (
   // Clock
   input  wire logic                            core_clk,
   // Bus as seen from the host
   input  wire logic [adc_port_pkg::DATA_W-1:0] bus_data_out,
   input  wire logic                            bus_data_oe,
   output logic                                 select_low_n,
   output logic                                 select_high,
   output logic                                 write_strobe,
   output logic                                 read_select_n,
   output logic [adc_port_pkg::DATA_W-1:0]      host_d,
   output logic                                 host_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   import adc_port_pkg::*;

   // Idle bus: nothing selected, bus released
   initial begin
      {select_low_n, select_high, write_strobe, read_select_n, host_oe} = 5'b10110;
      host_d = '0;
   end

   // Write: address on the top bits, held well past the strobe end
   task automatic wr(input logic [1:0] a, input logic [9:0] v);
      @(posedge core_clk);
      host_d       <= {a, v};
      host_oe      <= 1'b1;
      select_low_n <= 1'b0;
      select_high  <= 1'b1;
      write_strobe <= 1'b0;
      repeat (4) @(posedge core_clk);
      select_low_n <= 1'b1;
      write_strobe <= 1'b1;
      repeat (4) @(posedge core_clk);
      host_oe <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : wr

   // Read: wo uses the separate read select, cs gives the high select
   task automatic rd(input logic wo, cs, output logic [DATA_W-1:0] d, output logic oe);
      @(posedge core_clk);
      select_low_n  <= 1'b0;
      select_high   <= cs;
      read_select_n <= !wo;
      repeat (5) @(posedge core_clk);
      d = bus_data_out;
      oe = bus_data_oe;
      select_low_n  <= 1'b1;
      read_select_n <= 1'b1;
      repeat (5) @(posedge core_clk);
   endtask : rd
endmodule : host_model
